// *** hdl/rlmcr_cfg.svh ***
/*
 Register offsets, field positions, reset values and widths of the mapping configuration register bank.
 Assumes inclusion by its bare name from the package; the bank module uses its macros without including it.
*/
// Function
// - bit 4 of features register picks 16-bit (0) or 15-bit (1) sample halves.
// - bit 3 picks FIFO (0) or synchronous buffer (1) transmit interface.
// - bit 2 picks FIFO (0) or synchronous buffer (1) receive interface.
// - scheme field bits 1:0, 00 basic with one common rate, 11 reserved.
// - scheme value 01 selects IQ-sample-based advanced mapping.
// - scheme value 10 selects backward-compatible advanced mapping.
// - advanced schemes let each interface have own rate and standard.
// - basic register bits 12:8 hold active channel count.
// - basic register bits 4:0 hold oversampling factor.
// - count and oversampling apply only in scheme 00.
// - decode receive buffer control 0x150 and status 0x180 to 0x184.
// - decode transmit buffer control 0x160 and status 0x1A0 to 0x1A4.
// - PRBS config at 0x13C, PRBS status at 0x140 to 0x144.
// - container block length in frames, used only in advanced schemes.
`ifndef RLMCR_CFG_SVH
`define RLMCR_CFG_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define RLMCR_FEAT_OFS 12'h100
`define RLMCR_BASIC_OFS 12'h104
`define RLMCR_CBLK_OFS 12'h108
`define RLMCR_TIDX_OFS 12'h10C
`define RLMCR_TRX_OFS 12'h110
`define RLMCR_TTX_OFS 12'h114
`define RLMCR_OFSRX_OFS 12'h118
`define RLMCR_OFSTX_OFS 12'h11C
`define RLMCR_STRX_OFS 12'h120
`define RLMCR_STTX_OFS 12'h124
`define RLMCR_RXRDY_OFS 12'h128
`define RLMCR_TXRDY_OFS 12'h12C
`define RLMCR_TXST_OFS 12'h130
`define RLMCR_PRBS_OFS 12'h13C
`define RLMCR_PRBSST0_OFS 12'h140
`define RLMCR_PRBSST1_OFS 12'h144
`define RLMCR_RXBUF_OFS 12'h150
`define RLMCR_TXBUF_OFS 12'h160
`define RLMCR_RXBST0_OFS 12'h180
`define RLMCR_RXBST1_OFS 12'h184
`define RLMCR_TXBST0_OFS 12'h1A0
`define RLMCR_TXBST1_OFS 12'h1A4

// ----------------------------------------
// fields
// ----------------------------------------
`define RLMCR_NARROW_BIT 4
`define RLMCR_TXSYNC_BIT 3
`define RLMCR_RXSYNC_BIT 2
`define RLMCR_SCHEME_MSB 1
`define RLMCR_SCHEME_LSB 0
`define RLMCR_CHCNT_MSB 12
`define RLMCR_CHCNT_LSB 8
`define RLMCR_OVS_MSB 4
`define RLMCR_OVS_LSB 0
`define RLMCR_FEAT_MASK 32'h0000001F
`define RLMCR_BASIC_MASK 32'h00001F1F
`define RLMCR_RST_VAL 32'h00000000
`define RLMCR_GEN_RST 32'h00000000

`endif

// *** hdl/rlmcr_pkg.sv ***
/*
 Types of the mapping configuration register bank.
 Assumes rlmcr_cfg.svh is on the include path.
*/
package rlmcr_pkg;
`include "rlmcr_cfg.svh"

   typedef enum logic [1:0] {RLMCR_BASIC, RLMCR_ADV_IQ, RLMCR_ADV_BC, RLMCR_RSVD} rlmcr_scheme_t;

   typedef struct packed {
      logic [31:0] feat;
      logic [31:0] basic;
      logic [31:0] cblk;
      logic [31:0] tidx;
      logic [31:0] trx;
      logic [31:0] ttx;
      logic [31:0] ofsrx;
      logic [31:0] ofstx;
      logic [31:0] strx;
      logic [31:0] sttx;
      logic [31:0] rxrdy;
      logic [31:0] txrdy;
      logic [31:0] txst;
      logic [31:0] prbs;
      logic [31:0] rxbuf;
      logic [31:0] txbuf;
      logic [31:0] rdat;
      logic ack;
   } rlmcr_state_t;
endpackage

// *** hdl/rlmcr_regs.sv ***
/*
 Configuration register bank for the antenna-carrier sample mapping interface, as a classic Wishbone slave.
 Assumes one clock, an asynchronous active-low reset, and status words supplied by the mapping datapath.
*/
// Chosen here: register access over Wishbone.
`timescale 1ns/100ps
module rlmcr_regs
   import rlmcr_pkg::*;
#(
   parameter int CBLK_W = 16
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [11:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic err_o,
   // status from the datapath
   input wire logic [31:0] prbs_status0,
   input wire logic [31:0] prbs_status1,
   input wire logic [31:0] rx_buf_status0,
   input wire logic [31:0] rx_buf_status1,
   input wire logic [31:0] tx_buf_status0,
   input wire logic [31:0] tx_buf_status1,
   // configuration to the datapath
   output logic narrow_sample_select,
   output logic tx_sync_buffer_sel,
   output logic rx_sync_buffer_sel,
   output rlmcr_scheme_t map_scheme,
   output logic advanced_scheme,
   output logic [4:0] active_channel_count,
   output logic [4:0] oversample_factor,
   output logic [CBLK_W-1:0] container_block_length,
   output logic [31:0] mapping_table_index,
   output logic [31:0] rx_mapping_table_entry,
   output logic [31:0] tx_mapping_table_entry,
   output logic [31:0] rx_frame_offset,
   output logic [31:0] tx_frame_offset,
   output logic [31:0] rx_start_frame_offset,
   output logic [31:0] tx_start_frame_offset,
   output logic [31:0] rx_ready_threshold,
   output logic [31:0] tx_ready_threshold,
   output logic [31:0] tx_start_threshold,
   output logic [31:0] prbs_pattern_config,
   output logic [31:0] rx_sample_buffer_control,
   output logic [31:0] tx_sample_buffer_control
);

   localparam logic [31:0] CBLK_MASK = 32'((64'h1 << CBLK_W) - 64'h1);

   rlmcr_state_t st_r;
   rlmcr_state_t st_nxt;
   logic req;
   logic hit;
   logic [31:0] rval;
   logic [31:0] lane_mask;

   // ----------------------------------------
   // byte-lane merge
   // ----------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [31:0] lm, input logic [31:0] fm);
      merge = ((old & ~lm) | (wd & lm)) & fm;
   endfunction

   assign lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   assign req = cyc_i && stb_i && !st_r.ack;

   // ----------------------------------------
   // address decode and read mux
   // ----------------------------------------
   always_comb
   begin
      hit = 1'b1;
      rval = 32'h0;
      if (adr_i[1:0] != 2'h0)
      begin
         hit = 1'b0;
      end
      else if (adr_i == `RLMCR_FEAT_OFS)
      begin
         rval = st_r.feat;
      end
      else if (adr_i == `RLMCR_BASIC_OFS)
      begin
         rval = st_r.basic;
      end
      else if (adr_i == `RLMCR_CBLK_OFS)
      begin
         rval = st_r.cblk;
      end
      else if (adr_i == `RLMCR_TIDX_OFS)
      begin
         rval = st_r.tidx;
      end
      else if (adr_i == `RLMCR_TRX_OFS)
      begin
         rval = st_r.trx;
      end
      else if (adr_i == `RLMCR_TTX_OFS)
      begin
         rval = st_r.ttx;
      end
      else if (adr_i == `RLMCR_OFSRX_OFS)
      begin
         rval = st_r.ofsrx;
      end
      else if (adr_i == `RLMCR_OFSTX_OFS)
      begin
         rval = st_r.ofstx;
      end
      else if (adr_i == `RLMCR_STRX_OFS)
      begin
         rval = st_r.strx;
      end
      else if (adr_i == `RLMCR_STTX_OFS)
      begin
         rval = st_r.sttx;
      end
      else if (adr_i == `RLMCR_RXRDY_OFS)
      begin
         rval = st_r.rxrdy;
      end
      else if (adr_i == `RLMCR_TXRDY_OFS)
      begin
         rval = st_r.txrdy;
      end
      else if (adr_i == `RLMCR_TXST_OFS)
      begin
         rval = st_r.txst;
      end
      else if (adr_i == `RLMCR_PRBS_OFS)
      begin
         rval = st_r.prbs;
      end
      else if (adr_i == `RLMCR_PRBSST0_OFS)
      begin
         rval = prbs_status0;
      end
      else if (adr_i == `RLMCR_PRBSST1_OFS)
      begin
         rval = prbs_status1;
      end
      else if (adr_i == `RLMCR_RXBUF_OFS)
      begin
         rval = st_r.rxbuf;
      end
      else if (adr_i == `RLMCR_RXBST0_OFS)
      begin
         rval = rx_buf_status0;
      end
      else if (adr_i == `RLMCR_RXBST1_OFS)
      begin
         rval = rx_buf_status1;
      end
      else if (adr_i == `RLMCR_TXBUF_OFS)
      begin
         rval = st_r.txbuf;
      end
      else if (adr_i == `RLMCR_TXBST0_OFS)
      begin
         rval = tx_buf_status0;
      end
      else if (adr_i == `RLMCR_TXBST1_OFS)
      begin
         rval = tx_buf_status1;
      end
      else
      begin
         hit = 1'b0;
      end
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.ack = req;
      if (req && !we_i)
      begin
         st_nxt.rdat = rval;
      end
      if (req && we_i && hit)
      begin
         if (adr_i == `RLMCR_FEAT_OFS)
         begin
            // reserved bits dropped; value 11 is stored as written
            st_nxt.feat = merge(st_r.feat, dat_i, lane_mask, `RLMCR_FEAT_MASK);
         end
         else if (adr_i == `RLMCR_BASIC_OFS)
         begin
            st_nxt.basic = merge(st_r.basic, dat_i, lane_mask, `RLMCR_BASIC_MASK);
         end
         else if (adr_i == `RLMCR_CBLK_OFS)
         begin
            st_nxt.cblk = merge(st_r.cblk, dat_i, lane_mask, CBLK_MASK);
         end
         else if (adr_i == `RLMCR_TIDX_OFS)
         begin
            st_nxt.tidx = merge(st_r.tidx, dat_i, lane_mask, 32'hFFFFFFFF);
         end
         else if (adr_i == `RLMCR_TRX_OFS)
         begin
            st_nxt.trx = merge(st_r.trx, dat_i, lane_mask, 32'hFFFFFFFF);
         end
         else if (adr_i == `RLMCR_TTX_OFS)
         begin
            st_nxt.ttx = merge(st_r.ttx, dat_i, lane_mask, 32'hFFFFFFFF);
         end
         else if (adr_i == `RLMCR_OFSRX_OFS)
         begin
            st_nxt.ofsrx = merge(st_r.ofsrx, dat_i, lane_mask, 32'hFFFFFFFF);
         end
         else if (adr_i == `RLMCR_OFSTX_OFS)
         begin
            st_nxt.ofstx = merge(st_r.ofstx, dat_i, lane_mask, 32'hFFFFFFFF);
         end
         else if (adr_i == `RLMCR_STRX_OFS)
         begin
            st_nxt.strx = merge(st_r.strx, dat_i, lane_mask, 32'hFFFFFFFF);
         end
         else if (adr_i == `RLMCR_STTX_OFS)
         begin
            st_nxt.sttx = merge(st_r.sttx, dat_i, lane_mask, 32'hFFFFFFFF);
         end
         else if (adr_i == `RLMCR_RXRDY_OFS)
         begin
            st_nxt.rxrdy = merge(st_r.rxrdy, dat_i, lane_mask, 32'hFFFFFFFF);
         end
         else if (adr_i == `RLMCR_TXRDY_OFS)
         begin
            st_nxt.txrdy = merge(st_r.txrdy, dat_i, lane_mask, 32'hFFFFFFFF);
         end
         else if (adr_i == `RLMCR_TXST_OFS)
         begin
            st_nxt.txst = merge(st_r.txst, dat_i, lane_mask, 32'hFFFFFFFF);
         end
         else if (adr_i == `RLMCR_PRBS_OFS)
         begin
            st_nxt.prbs = merge(st_r.prbs, dat_i, lane_mask, 32'hFFFFFFFF);
         end
         else if (adr_i == `RLMCR_RXBUF_OFS)
         begin
            st_nxt.rxbuf = merge(st_r.rxbuf, dat_i, lane_mask, 32'hFFFFFFFF);
         end
         else if (adr_i == `RLMCR_TXBUF_OFS)
         begin
            st_nxt.txbuf = merge(st_r.txbuf, dat_i, lane_mask, 32'hFFFFFFFF);
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // bus answer
   // ----------------------------------------
   assign dat_o = st_r.rdat;
   assign ack_o = st_r.ack;
   assign err_o = 1'b0;

   // ----------------------------------------
   // configuration outputs
   // ----------------------------------------
   assign narrow_sample_select = st_r.feat[`RLMCR_NARROW_BIT];
   assign tx_sync_buffer_sel = st_r.feat[`RLMCR_TXSYNC_BIT];
   assign rx_sync_buffer_sel = st_r.feat[`RLMCR_RXSYNC_BIT];
   assign map_scheme = rlmcr_scheme_t'(st_r.feat[`RLMCR_SCHEME_MSB:`RLMCR_SCHEME_LSB]);
   // per-interface rates allowed for either advanced scheme
   assign advanced_scheme = (map_scheme == RLMCR_ADV_IQ) || (map_scheme == RLMCR_ADV_BC);
   // basic counts forced to zero outside the basic scheme
   assign active_channel_count = (map_scheme == RLMCR_BASIC) ?
                                 st_r.basic[`RLMCR_CHCNT_MSB:`RLMCR_CHCNT_LSB] : 5'h0;
   assign oversample_factor = (map_scheme == RLMCR_BASIC) ?
                              st_r.basic[`RLMCR_OVS_MSB:`RLMCR_OVS_LSB] : 5'h0;
   assign container_block_length = advanced_scheme ? st_r.cblk[CBLK_W-1:0] : '0;
   assign mapping_table_index = st_r.tidx;
   assign rx_mapping_table_entry = st_r.trx;
   assign tx_mapping_table_entry = st_r.ttx;
   assign rx_frame_offset = st_r.ofsrx;
   assign tx_frame_offset = st_r.ofstx;
   assign rx_start_frame_offset = st_r.strx;
   assign tx_start_frame_offset = st_r.sttx;
   assign rx_ready_threshold = st_r.rxrdy;
   assign tx_ready_threshold = st_r.txrdy;
   assign tx_start_threshold = st_r.txst;
   assign prbs_pattern_config = st_r.prbs;
   assign rx_sample_buffer_control = st_r.rxbuf;
   assign tx_sample_buffer_control = st_r.txbuf;

endmodule

// *** tb/rlmcr_regs_monitor.sv ***
/*
 Port checker of the mapping configuration register bank.
 Assumes it is bound onto every rlmcr_regs instance.
*/
`timescale 1ns/100ps
module rlmcr_regs_monitor
   import rlmcr_pkg::*;
#(
   parameter int CBLK_W = 16
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [11:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic err_o,
   // configuration
   input wire logic narrow_sample_select,
   input wire logic tx_sync_buffer_sel,
   input wire logic rx_sync_buffer_sel,
   input wire rlmcr_scheme_t map_scheme,
   input wire logic advanced_scheme,
   input wire logic [4:0] active_channel_count,
   input wire logic [4:0] oversample_factor,
   input wire logic [CBLK_W-1:0] container_block_length
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   chk_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered next cycle");
   chk_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   chk_no_err: assert property (!err_o)
      else $error("error response raised");
   chk_adv_decode: assert property (advanced_scheme == (^map_scheme))
      else $error("advanced flag wrong for scheme");
   chk_basic_gate: assert property (map_scheme != RLMCR_BASIC |-> active_channel_count == 5'h00 && oversample_factor == 5'h00)
      else $error("basic counts active outside basic scheme");
   chk_cblk_gate: assert property (!advanced_scheme |-> container_block_length == '0)
      else $error("block length active outside advanced scheme");
   chk_feat_cause: assert property ($changed({narrow_sample_select, tx_sync_buffer_sel, rx_sync_buffer_sel, map_scheme})
      |-> ack_o && we_i && adr_i == 12'h100)
      else $error("feature outputs changed without write");
   chk_cnt_cause: assert property ($changed({active_channel_count, oversample_factor})
      |-> ack_o && we_i && (adr_i == 12'h100 || adr_i == 12'h104))
      else $error("basic counts changed without write");
   chk_unmap_zero: assert property (ack_o && !we_i && adr_i == 12'h1FC |-> dat_o == 32'h00000000)
      else $error("unmapped read not zero");

   cover property (ack_o && we_i && adr_i == 12'h100);
   cover property (advanced_scheme);
   cover property (active_channel_count != 5'h00);
   cover property (ack_o && !we_i && adr_i == 12'h180);
endmodule

bind rlmcr_regs rlmcr_regs_monitor #(.CBLK_W(CBLK_W)) u_mon (.core_clk(core_clk), .rst_b(rst_b), .cyc_i(cyc_i),
   .stb_i(stb_i), .container_block_length(container_block_length),
   .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
   .narrow_sample_select(narrow_sample_select), .tx_sync_buffer_sel(tx_sync_buffer_sel),
   .rx_sync_buffer_sel(rx_sync_buffer_sel), .map_scheme(map_scheme), .advanced_scheme(advanced_scheme),
   .active_channel_count(active_channel_count), .oversample_factor(oversample_factor));

// *** tb/rlmcr_regs_tb.sv ***
/*
 Self-checking bench of the mapping configuration register bank.
 Assumes the bank answers each bus request with a one-cycle ack.
*/
`timescale 1ns/100ps
module rlmcr_regs_tb
   import rlmcr_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_b, cyc, stb, we, ack_o, err_o, narrow, txs, rxs, adv;
   logic [11:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, dat_o, seed, d, b, k, q;
   logic [31:0] st [6];
   rlmcr_scheme_t scheme;
   logic [4:0] cnt, ovs;
   logic [15:0] cbl;
   wire [12:0][31:0] cfg;
   logic [11:0] offs [16] = '{12'h100, 12'h104, 12'h108, 12'h10C, 12'h110, 12'h114, 12'h118, 12'h11C,
      12'h120, 12'h124, 12'h128, 12'h12C, 12'h130, 12'h13C, 12'h150, 12'h160};
   logic [11:0] sofs [6] = '{12'h140, 12'h144, 12'h180, 12'h184, 12'h1A0, 12'h1A4};
   int n_mismatch = 0;
   int tests_run = 0;

   always #10 core_clk = ~core_clk;

   rlmcr_regs #(.CBLK_W(16)) dut (.core_clk(core_clk), .rst_b(rst_b), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
      .prbs_status0(st[0]), .prbs_status1(st[1]), .rx_buf_status0(st[2]), .rx_buf_status1(st[3]),
      .tx_buf_status0(st[4]), .tx_buf_status1(st[5]), .narrow_sample_select(narrow),
      .tx_sync_buffer_sel(txs), .rx_sync_buffer_sel(rxs), .map_scheme(scheme), .advanced_scheme(adv),
      .active_channel_count(cnt), .oversample_factor(ovs), .container_block_length(cbl),
      .mapping_table_index(cfg[0]), .rx_mapping_table_entry(cfg[1]), .tx_mapping_table_entry(cfg[2]),
      .rx_frame_offset(cfg[3]), .tx_frame_offset(cfg[4]), .rx_start_frame_offset(cfg[5]),
      .tx_start_frame_offset(cfg[6]), .rx_ready_threshold(cfg[7]), .tx_ready_threshold(cfg[8]),
      .tx_start_threshold(cfg[9]), .prbs_pattern_config(cfg[10]), .rx_sample_buffer_control(cfg[11]),
      .tx_sample_buffer_control(cfg[12]));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic f_adv(input logic [1:0] s);
      return s == 2'h1 || s == 2'h2;
   endfunction

   function automatic logic [31:0] f_lanes(input logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   function automatic logic [31:0] f_cnt(input logic [1:0] s, input logic [31:0] v);
      return (s == 2'h0) ? {22'h0, v[12:8], v[4:0]} : 32'h0;
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] v, output logic [31:0] r);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (ack_o !== 1'b1 && n < 20);
      if (n >= 20)
         chk("ack", 32'h1, 32'h0);
      r = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic [31:0] r;
      wb(1'b1, a, v, r);
   endtask

   task give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      repeat (5000) @(posedge core_clk);
      n_mismatch++;
      give_verdict;
   end

   initial
   begin
      rst_b = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 12'h000;
      sel = 4'hF;
      wdat = 32'h0;
      foreach (st[i]) st[i] = 32'h0;
      seed = 32'h6B89;
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      foreach (offs[i])
      begin
         wb(1'b0, offs[i], 32'h0, q);
         chk("reset value", 32'h0, q);
      end
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         d = xs();
         d[1:0] = 2'(i % 3);
         b = xs();
         k = xs();
         wr(12'h100, d);
         wr(12'h104, b);
         wr(12'h108, k);
         wb(1'b0, 12'h100, 32'h0, q);
         chk("feature readback", d & 32'h1F, q);
         chk("feature outputs", {27'h0, d[4:0]}, {27'h0, narrow, txs, rxs, scheme});
         chk("advanced flag", {31'h0, f_adv(d[1:0])}, {31'h0, adv});
         wb(1'b0, 12'h104, 32'h0, q);
         chk("basic readback", b & 32'h1F1F, q);
         chk("basic outputs", f_cnt(d[1:0], b), {22'h0, cnt, ovs});
         chk("block length", f_adv(d[1:0]) ? {16'h0, k[15:0]} : 32'h0, {16'h0, cbl});
      end
      $display("test schemes done");
      for (int i = 3; i < 16; i++)
      begin
         d = xs();
         b = xs();
         k = xs();
         wr(offs[i], d);
         sel <= k[3:0];
         wr(offs[i], b);
         sel <= 4'hF;
         d = (d & ~f_lanes(k[3:0])) | (b & f_lanes(k[3:0]));
         wb(1'b0, offs[i], 32'h0, q);
         chk("plain register", d, q);
         chk("config output", d, cfg[i - 3]);
      end
      foreach (st[i]) st[i] <= xs();
      wr(12'h180, 32'hFFFFFFFF);
      foreach (sofs[i])
      begin
         wb(1'b0, sofs[i], 32'h0, q);
         chk("status word", st[i], q);
      end
      $display("test decode done");
      wr(12'h1FC, xs());
      wb(1'b0, 12'h1FC, 32'h0, q);
      chk("unmapped read", 32'h0, q);
      wb(1'b0, 12'h102, 32'h0, q);
      chk("misaligned read", 32'h0, q);
      rst_b <= 1'b0;
      @(posedge core_clk);
      rst_b <= 1'b1;
      wb(1'b0, 12'h104, 32'h0, q);
      chk("second reset", 32'h0, q);
      $display("test refusal done");
      give_verdict;
   end
endmodule
